// >>> logic/dot_matrix_lcd_driver_control.sv
// Dot matrix LCD driver control: registers, display memory scan and drive level selection.
//
// Notes on behaviour
// - Eight commons, sixty segments, up to 480 dots.
// - Fixed 1/8 duty, 1/4 bias, four levels.
// - Frame is low-frequency clock divided by 1024.
// - Display memory F000H-F077H feeds segment scan.
// - Bit one gives ON, zero gives OFF.
// - Display memory read/write; all 120 words feed the scan.
// - All-on bit forces ON on every segment.
// - All-off bit forces OFF on every segment.
// - All-on wins when both override bits set.
// - Reset blanks display: power off, all-off set.
// - Power bit enables drive; off means ground.
// - Reference select: one second, zero first voltage.
// - Four-bit contrast code picks one of 16.
// - External drive option ignores contrast and reference.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module dot_matrix_lcd_driver_control #(
    parameter bit EXTERNAL_DRIVE = 1'b0,
    parameter int FRAME_DIVIDE   = lcd_drv_pkg::FRAME_DIVIDE
) (
    // Clock and reset.
    input  wire logic                                                sys_clk,
    input  wire logic                                                rst,
    // Register bus.
    input  wire lcd_drv_pkg::reg_req_s                               busReq,
    output logic [lcd_drv_pkg::DATA_W-1:0]                           rdData,
    // Low-frequency oscillator pin.
    input  wire logic                                                lowFreqOscClock,
    // Panel drive levels.
    output var lcd_drv_pkg::drive_level_e [lcd_drv_pkg::COM_COUNT-1:0] commonOutputs,
    output var lcd_drv_pkg::drive_level_e [lcd_drv_pkg::SEG_COUNT-1:0] segmentOutputs,
    // Drive voltage generator control.
    output logic                                                     driveVoltageEnable,
    output logic                                                     regulatorReferenceSelect,
    output logic [3:0]                                               regulatorContrastCode
);
    import lcd_drv_pkg::*;

    localparam int DIV_W = $clog2(FRAME_DIVIDE);
    localparam int SEG_W = $clog2(SEG_COUNT);

    // ==========================================================================
    // Control registers.
    power_ref_s  powerReg;
    override_s   overrideReg;
    logic [3:0]  contrastReg;
    logic        inDisp;
    logic [3:0]  regRdValue;

    assign inDisp = (busReq.addr >= DISP_FIRST) && (busReq.addr <= DISP_LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            powerReg <= POWER_RESET;
        end else if (busReq.wrEn && busReq.addr == REG_POWER) begin
            powerReg <= busReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overrideReg <= OVERRIDE_RESET;
        end else if (busReq.wrEn && busReq.addr == REG_OVERRIDE) begin
            overrideReg <= busReq.wrData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            contrastReg <= CONTRAST_RESET;
        end else if (busReq.wrEn && busReq.addr == REG_CONTRAST) begin
            contrastReg <= busReq.wrData;
        end
    end

    always_comb begin
        regRdValue = '0;
        if (busReq.rdEn) begin
            case (busReq.addr)
                REG_POWER:    regRdValue = powerReg;
                REG_OVERRIDE: regRdValue = overrideReg;
                REG_CONTRAST: regRdValue = contrastReg;
                default:      regRdValue = '0;
            endcase
        end
    end

    // Regulator controls; with external drive levels the contrast and reference are moot.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            driveVoltageEnable       <= 1'b0;
            regulatorReferenceSelect <= 1'b0;
            regulatorContrastCode    <= CONTRAST_RESET;
        end else begin
            driveVoltageEnable       <= powerReg.driveVoltageEnable;
            regulatorReferenceSelect <= EXTERNAL_DRIVE ? 1'b0 : powerReg.referenceVoltageSelect;
            regulatorContrastCode    <= EXTERNAL_DRIVE ? 4'h0 : contrastReg;
        end
    end

    // ==========================================================================
    // Display memory.
    logic [DISP_ADDR_W-1:0] scanAddr;
    logic [DATA_W-1:0]      scanData;

    display_memory #(
        .WORDS  (DISP_WORDS),
        .ADDR_W (DISP_ADDR_W),
        .DATA_W (DATA_W)
    ) u_mem (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .cpuAddr    (busReq.addr[DISP_ADDR_W-1:0]),
        .cpuWrEn    (busReq.wrEn && inDisp),
        .cpuWrData  (busReq.wrData),
        .cpuRdSel   (busReq.rdEn && inDisp),
        .cpuAltData (regRdValue),
        .cpuRdData  (rdData),
        .scanAddr   (scanAddr),
        .scanRdData (scanData)
    );

    // ==========================================================================
    // Low-frequency clock synchroniser and frame divider.
    logic             oscMeta;
    logic             oscSync;
    logic             oscLast;
    logic             oscTick;
    logic [DIV_W-1:0] oscCount;
    logic [COM_W-1:0] comIdx;
    logic             polarity;
    logic             comBoundary;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oscMeta <= 1'b0;
            oscSync <= 1'b0;
            oscLast <= 1'b0;
        end else begin
            oscMeta <= lowFreqOscClock;
            oscSync <= oscMeta;
            oscLast <= oscSync;
        end
    end

    assign oscTick     = oscSync && !oscLast;
    assign comIdx      = oscCount[DIV_W-1 -: COM_W];
    assign comBoundary = oscTick && (oscCount[DIV_W-COM_W-1:0] == '1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oscCount <= '0;
            polarity <= 1'b0;
        end else if (oscTick) begin
            oscCount <= oscCount + 1'b1;
            if (oscCount == '1) begin
                polarity <= !polarity;
            end
        end
    end

    // ==========================================================================
    // Line fetch: during one common period the next common's 60 bits are read.
    scan_state_e          scanState;
    logic [SEG_W-1:0]     segIdx;
    logic [COM_W-1:0]     fetchCom;
    logic                 capValid;
    logic [SEG_W-1:0]     capSeg;
    logic [SEG_COUNT-1:0] fetchLine;
    logic [SEG_COUNT-1:0] shownLine;

    assign fetchCom = comIdx + 1'b1;
    assign scanAddr = {segIdx, fetchCom[COM_W-1]};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scanState <= SCAN_IDLE;
            segIdx    <= '0;
        end else begin
            case (scanState)
                SCAN_IDLE: begin
                    scanState <= SCAN_READ;
                    segIdx    <= '0;
                end
                SCAN_READ: begin
                    if (segIdx == SEG_W'(SEG_COUNT - 1)) begin
                        scanState <= SCAN_HOLD;
                    end
                    segIdx <= segIdx + 1'b1;
                end
                SCAN_HOLD: begin
                    if (comBoundary) begin
                        scanState <= SCAN_READ;
                        segIdx    <= '0;
                    end
                end
                default: scanState <= SCAN_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capValid <= 1'b0;
            capSeg   <= '0;
        end else begin
            capValid <= (scanState == SCAN_READ);
            capSeg   <= segIdx;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetchLine <= '0;
        end else if (capValid) begin
            fetchLine[capSeg] <= scanData[fetchCom[COM_W-2:0]];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shownLine <= '0;
        end else if (comBoundary) begin
            shownLine <= fetchLine;
        end
    end

    // ==========================================================================
    // Drive level selection for every common and segment.
    drive_level_e [COM_COUNT-1:0] next_common;
    drive_level_e [SEG_COUNT-1:0] next_segment;

    for (genvar c = 0; c < COM_COUNT; c++) begin : g_com
        always_comb begin
            if (!powerReg.driveVoltageEnable) begin
                next_common[c] = LVL_VSS;
            end else if (comIdx == COM_W'(c)) begin
                next_common[c] = polarity ? LVL_VSS : LVL_FIVE;
            end else begin
                next_common[c] = polarity ? LVL_FOUR : LVL_ONE;
            end
        end
    end

    for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
        logic dotOn;
        always_comb begin
            dotOn = overrideReg.allDotsOn
                || (!overrideReg.allDotsOff && shownLine[s]);
            if (!powerReg.driveVoltageEnable) begin
                next_segment[s] = LVL_VSS;
            end else if (dotOn) begin
                next_segment[s] = polarity ? LVL_FIVE : LVL_VSS;
            end else begin
                next_segment[s] = LVL_TWO;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            commonOutputs  <= {COM_COUNT{LVL_VSS}};
            segmentOutputs <= {SEG_COUNT{LVL_VSS}};
        end else begin
            commonOutputs  <= next_common;
            segmentOutputs <= next_segment;
        end
    end

    // ==========================================================================
    // Assertions.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_power_off_ground;
        !powerReg.driveVoltageEnable |=>
            (segmentOutputs == {SEG_COUNT{LVL_VSS}}) && (commonOutputs == {COM_COUNT{LVL_VSS}});
    endproperty
    a_power_off_ground: assert property (p_power_off_ground)
        else $error("Drive levels not at ground while power is off.");

    property p_all_on;
        powerReg.driveVoltageEnable && overrideReg.allDotsOn && !overrideReg.allDotsOff |=>
            segmentOutputs == {SEG_COUNT{$past(polarity) ? LVL_FIVE : LVL_VSS}};
    endproperty
    a_all_on: assert property (p_all_on)
        else $error("All-on override did not give ON on every segment.");

    property p_all_off;
        powerReg.driveVoltageEnable && !overrideReg.allDotsOn && overrideReg.allDotsOff |=>
            segmentOutputs == {SEG_COUNT{LVL_TWO}};
    endproperty
    a_all_off: assert property (p_all_off)
        else $error("All-off override did not give OFF on every segment.");

    property p_on_wins;
        powerReg.driveVoltageEnable && overrideReg.allDotsOn && overrideReg.allDotsOff |=>
            segmentOutputs == {SEG_COUNT{$past(polarity) ? LVL_FIVE : LVL_VSS}};
    endproperty
    a_on_wins: assert property (p_on_wins)
        else $error("All-off took effect while all-on was set.");

    property p_frame_flip;
        $changed(polarity) |-> $past(oscTick) && ($past(oscCount) == DIV_W'(FRAME_DIVIDE - 1));
    endproperty
    a_frame_flip: assert property (p_frame_flip)
        else $error("Frame polarity changed away from the frame end.");

    property p_selected_common;
        powerReg.driveVoltageEnable |=>
            commonOutputs[$past(comIdx)] == ($past(polarity) ? LVL_VSS : LVL_FIVE);
    endproperty
    a_selected_common: assert property (p_selected_common)
        else $error("Scanned common not at its selection level.");

    sequence s_fetch_start;
        (scanState == SCAN_READ) && ($past(scanState) != SCAN_READ);
    endsequence
    sequence s_fetch_run;
        ##59 (scanState == SCAN_READ) ##1 (scanState == SCAN_HOLD);
    endsequence
    property p_fetch_len;
        s_fetch_start |-> s_fetch_run;
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("Line fetch did not read exactly sixty segments.");

    sequence s_write_then_read;
        (busReq.wrEn && inDisp) ##1 (busReq.rdEn && busReq.addr == $past(busReq.addr));
    endsequence
    property p_mem_readback;
        s_write_then_read |=> rdData == $past(busReq.wrData, 2);
    endproperty
    a_mem_readback: assert property (p_mem_readback)
        else $error("Display memory read did not return the written nibble.");

    property p_contrast_out;
        busReq.wrEn && busReq.addr == REG_CONTRAST |=> ##1
            regulatorContrastCode == (EXTERNAL_DRIVE ? 4'h0 : $past(busReq.wrData, 2));
    endproperty
    a_contrast_out: assert property (p_contrast_out)
        else $error("Contrast code output does not follow the written value.");

endmodule : dot_matrix_lcd_driver_control

`default_nettype wire

// >>> logic/lcd_drv_pkg.sv
// Shared constants, types and register layout of the dot matrix LCD driver control.
`default_nettype none

package lcd_drv_pkg;

    // ==========================================================================
    // Panel geometry and scan timing.
    localparam int COM_COUNT    = 8;
    localparam int SEG_COUNT    = 60;
    localparam int FRAME_DIVIDE = 1024;
    localparam int COM_W        = $clog2(COM_COUNT);

    // ==========================================================================
    // Display memory window and control register addresses.
    localparam logic [15:0] DISP_FIRST   = 16'hF000;
    localparam logic [15:0] DISP_LAST    = 16'hF077;
    localparam int          DISP_WORDS   = 120;
    localparam int          DISP_ADDR_W  = 7;
    localparam logic [15:0] REG_POWER    = 16'hFF60;
    localparam logic [15:0] REG_OVERRIDE = 16'hFF61;
    localparam logic [15:0] REG_CONTRAST = 16'hFF62;
    localparam int          DATA_W       = 4;

    // ==========================================================================
    // Drive levels of the four-voltage, one-quarter bias scheme plus ground.
    typedef enum logic [2:0] {
        LVL_VSS  = 3'h0,
        LVL_ONE  = 3'h1,
        LVL_TWO  = 3'h2,
        LVL_FOUR = 3'h3,
        LVL_FIVE = 3'h4
    } drive_level_e;

    // Register bus request from the CPU side.
    typedef struct packed {
        logic [15:0] addr;
        logic [3:0]  wrData;
        logic        wrEn;
        logic        rdEn;
    } reg_req_s;

    // Power and reference register, bit 3 down to bit 0.
    typedef struct packed {
        logic spareBitThree;
        logic spareBitTwo;
        logic referenceVoltageSelect;
        logic driveVoltageEnable;
    } power_ref_s;

    // Display override register, bit 3 down to bit 0.
    typedef struct packed {
        logic spareExpansionBit;
        logic allDotsOff;
        logic allDotsOn;
        logic sparePageBit;
    } override_s;

    localparam power_ref_s  POWER_RESET    = 4'h0;
    localparam override_s   OVERRIDE_RESET = 4'h4;
    localparam logic [3:0]  CONTRAST_RESET = 4'h0;

    // Display memory fetch sequencer.
    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_READ = 3'b010,
        SCAN_HOLD = 3'b100
    } scan_state_e;

endpackage : lcd_drv_pkg

`default_nettype wire

// >>> logic/display_memory.sv
// Display memory: CPU read/write port and a scan read port, both with registered reads.
`timescale 1ns/100ps
`default_nettype none

module display_memory #(
    parameter int WORDS  = 120,
    parameter int ADDR_W = 7,
    parameter int DATA_W = 4
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // CPU port.
    input  wire logic [ADDR_W-1:0] cpuAddr,
    input  wire logic              cpuWrEn,
    input  wire logic [DATA_W-1:0] cpuWrData,
    input  wire logic              cpuRdSel,
    input  wire logic [DATA_W-1:0] cpuAltData,
    output logic      [DATA_W-1:0] cpuRdData,
    // Scan port.
    input  wire logic [ADDR_W-1:0] scanAddr,
    output logic      [DATA_W-1:0] scanRdData
);

    // Contents are not reset; software must fill the used words.
    logic [DATA_W-1:0] mem [WORDS];

    always_ff @(posedge sys_clk) begin
        if (cpuWrEn) begin
            mem[cpuAddr] <= cpuWrData;
        end
    end

    // The CPU read register also carries register-file data so the bus answer is one flop.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpuRdData <= '0;
        end else begin
            cpuRdData <= cpuRdSel ? mem[cpuAddr] : cpuAltData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scanRdData <= '0;
        end else begin
            scanRdData <= mem[scanAddr];
        end
    end

endmodule : display_memory

`default_nettype wire

// >>> sim/lcd_panel_model.sv
// Behavioural dot matrix panel that decodes the selected common and the lit dots.
`timescale 1ns/100ps
`default_nettype none

module lcd_panel_model (
    // Drive levels from the controller.
    input  wire lcd_drv_pkg::drive_level_e [lcd_drv_pkg::COM_COUNT-1:0] commonOutputs,
    input  wire lcd_drv_pkg::drive_level_e [lcd_drv_pkg::SEG_COUNT-1:0] segmentOutputs,
    // Decoded view of the panel.
    output logic [2:0]                                                  selCom,
    output logic                                                        comValid,
    output logic [59:0]                                                 onMask
);
    import lcd_drv_pkg::*;

    // ==========================================================================
    // Decode
    // A dot is lit only when it sees the full four-level swing between its
    // common and its segment; unless exactly one common is selected and the rest are idle, the whole panel stays dark.
    always_comb begin
        int           hits;
        drive_level_e selLvl;
        drive_level_e idleLvl;
        hits = 0;
        selCom = 3'h0;
        selLvl = LVL_VSS;
        idleLvl = LVL_VSS;
        for (int c = 0; c < COM_COUNT; c++) begin
            if (commonOutputs[c] == LVL_FIVE || commonOutputs[c] == LVL_VSS) begin
                hits++;
                selCom = 3'(c);
                selLvl = commonOutputs[c];
            end
        end
        idleLvl = (selLvl == LVL_FIVE) ? LVL_ONE : LVL_FOUR;
        comValid = (hits == 1);
        for (int c = 0; c < COM_COUNT; c++) begin
            if (c != int'(selCom) && commonOutputs[c] != idleLvl) begin
                comValid = 1'b0;
            end
        end
        for (int s = 0; s < SEG_COUNT; s++) begin
            onMask[s] = (segmentOutputs[s] == ((selLvl == LVL_FIVE) ? LVL_VSS : LVL_FIVE));
        end
        if (!comValid) begin
            onMask = 60'h0;
        end
    end

endmodule : lcd_panel_model

`default_nettype wire

// >>> sim/dot_matrix_lcd_driver_control_tb.sv
// Self-checking testbench of the dot matrix LCD driver control.
`timescale 1ns/100ps
`default_nettype none

module dot_matrix_lcd_driver_control_tb;
    import lcd_drv_pkg::*;

    localparam int  FRAME_SIM = 16;
    localparam real OSC_HALF  = 410.3;
    localparam real FRAME_CYC = FRAME_SIM * 2.0 * OSC_HALF / 20.0;

    logic                         sys_clk = 1'b0;
    logic                         rst = 1'b1;
    logic                         lowFreqOscClock = 1'b0;
    reg_req_s                     busReq = '0;
    logic [DATA_W-1:0]            rdData;
    drive_level_e [COM_COUNT-1:0] commonOutputs;
    drive_level_e [SEG_COUNT-1:0] segmentOutputs;
    logic                         driveVoltageEnable;
    logic                         regulatorReferenceSelect;
    logic [3:0]                   regulatorContrastCode;
    logic [2:0]                   selCom;
    logic                         comValid;
    logic [59:0]                  onMask;
    logic [3:0]                   mem [DISP_WORDS];
    int                           failCount = 0;
    int                           checks = 0;
    int                           cyc = 0;
    int                           t0;

    always #10 sys_clk = ~sys_clk;
    // The oscillator is off-grid so its rising edges never coincide with the clock.
    always #(OSC_HALF) lowFreqOscClock = ~lowFreqOscClock;
    always @(posedge sys_clk) cyc <= cyc + 1;

    dot_matrix_lcd_driver_control #(.EXTERNAL_DRIVE(1'b0), .FRAME_DIVIDE(FRAME_SIM))
        dot_matrix_lcd_driver_control_inst (
        .sys_clk                  (sys_clk),
        .rst                      (rst),
        .busReq                   (busReq),
        .rdData                   (rdData),
        .lowFreqOscClock          (lowFreqOscClock),
        .commonOutputs            (commonOutputs),
        .segmentOutputs           (segmentOutputs),
        .driveVoltageEnable       (driveVoltageEnable),
        .regulatorReferenceSelect (regulatorReferenceSelect),
        .regulatorContrastCode    (regulatorContrastCode)
    );

    lcd_panel_model lcd_panel_model_inst (
        .commonOutputs  (commonOutputs),
        .segmentOutputs (segmentOutputs),
        .selCom         (selCom),
        .comValid       (comValid),
        .onMask         (onMask)
    );

    // ==========================================================================
    // Tasks
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        busReq <= {a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq <= '0;
    endtask : wr

    task automatic rdChk(input logic [15:0] a, input logic [3:0] exp);
        @(posedge sys_clk);
        busReq <= {a, 4'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
        #1;
        chk(64'(rdData), 64'(exp));
    endtask : rdChk

    // Writes an address and reads it back in the very next cycle, with no gap.
    task automatic wrRdChk(input logic [15:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        busReq <= {a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq <= {a, 4'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
        #1;
        chk(64'(rdData), 64'(d));
    endtask : wrRdChk

    task automatic doReset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : doReset

    task automatic checkReset();
        #1;
        chk(64'({driveVoltageEnable, regulatorReferenceSelect, regulatorContrastCode}), 64'h0);
        chk(64'({|commonOutputs, |segmentOutputs}), 64'h0);
        rdChk(REG_POWER, 4'h0);
        rdChk(REG_OVERRIDE, 4'h4);
        rdChk(REG_CONTRAST, 4'h0);
    endtask : checkReset

    // Waits, with a bound, until the panel shows common c as selected.
    task automatic waitCom(input int c);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (!(comValid === 1'b1 && int'(selCom) == c) && n < 3000);
        if (n >= 3000) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, selCom, c);
        end
    endtask : waitCom

    // Mode 0 shows memory, 1 every dot lit, 2 every dot dark.
    task automatic scanCheck(input int mode);
        logic [63:0] exp;
        for (int c = 0; c < COM_COUNT; c++) begin
            waitCom(c);
            repeat (3) @(posedge sys_clk);
            #1;
            exp = '0;
            for (int s = 0; s < SEG_COUNT; s++) begin
                exp[s] = (mode == 1) ? 1'b1 : (mode == 0) ? mem[2 * s + c / 4][c % 4] : 1'b0;
            end
            chk(64'(onMask), exp);
        end
    endtask : scanCheck

    // ==========================================================================
    // Tests
    initial begin
        doReset();
        checkReset();
        wr(REG_POWER, 4'hE);
        rdChk(REG_POWER, 4'hE);
        chk(64'({regulatorReferenceSelect, driveVoltageEnable, |commonOutputs}), 64'h4);
        wr(REG_OVERRIDE, 4'h9);
        rdChk(REG_OVERRIDE, 4'h9);
        for (int i = 0; i < 16; i++) begin
            wr(REG_CONTRAST, 4'(i));
            rdChk(REG_CONTRAST, 4'(i));
            chk(64'(regulatorContrastCode), 64'(i));
        end
        wr(REG_CONTRAST, 4'h7);
        rdChk(REG_CONTRAST, 4'h7);
        wr(16'hFF63, 4'hF);
        rdChk(16'hFF63, 4'h0);
        rdChk(DISP_LAST + 16'h1, 4'h0);
        for (int i = 0; i < DISP_WORDS; i++) begin
            mem[i] = 4'(i * 7 + 3);
            wr(DISP_FIRST + 16'(i), mem[i]);
        end
        for (int i = 0; i < DISP_WORDS; i++) begin
            rdChk(DISP_FIRST + 16'(i), mem[i]);
        end
        wrRdChk(DISP_FIRST + 16'h5, mem[5]);
        wr(REG_POWER, 4'h1);
        // Settling wait, scaled far down from the regulator's real start-up time.
        repeat (20) @(posedge sys_clk);
        #1;
        chk(64'(driveVoltageEnable), 64'h1);
        wr(REG_OVERRIDE, 4'h4);
        scanCheck(2);
        wr(REG_OVERRIDE, 4'h0);
        scanCheck(0);
        waitCom(7);
        waitCom(0);
        t0 = cyc;
        waitCom(7);
        waitCom(0);
        chk(64'(real'(cyc - t0) > FRAME_CYC - 3.0 && real'(cyc - t0) < FRAME_CYC + 3.0), 64'h1);
        wr(REG_OVERRIDE, 4'h2);
        scanCheck(1);
        wr(REG_OVERRIDE, 4'h6);
        scanCheck(1);
        wr(REG_OVERRIDE, 4'h0);
        scanCheck(0);
        wr(REG_POWER, 4'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(64'({driveVoltageEnable, |commonOutputs, |segmentOutputs}), 64'h0);
        doReset();
        checkReset();
        print_verdict();
    end

    // The tests need about 5000 clocks; this limit leaves a wide margin.
    initial begin
        #1000000;
        failCount++;
        print_verdict();
    end

endmodule : dot_matrix_lcd_driver_control_tb

`default_nettype wire
